// ### hdl/sot_pkg.sv
package sot_pkg;

	// ------------------------------------------------------------
	// time base
	// ------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS  = 100;                  // hclk period
	localparam int unsigned CLK_PER_US     = 1000 / CLK_PERIOD_NS; // cycles per microsecond

	// ------------------------------------------------------------
	// timing limits
	// ------------------------------------------------------------
	localparam int unsigned FLAG_LAT_MAX_US  = 25;   // fault to output latency
	localparam int unsigned FLAG_LAT_CYC     = FLAG_LAT_MAX_US * CLK_PER_US;
	localparam int unsigned FAST_1X_MAX_NS   = 650;  // fast path, 1x range
	localparam int unsigned FAST_1X_CYC      = FAST_1X_MAX_NS / CLK_PERIOD_NS;
	localparam int unsigned FAST_4X_MAX_NS   = 750;  // fast path, 4x range
	localparam int unsigned FAST_4X_CYC      = FAST_4X_MAX_NS / CLK_PERIOD_NS;
	localparam int unsigned BUS_ACT_MAX_US   = 0;    // bus open after self test

	// ------------------------------------------------------------
	// selectable delays, microseconds; fast filter step, nanoseconds
	// ------------------------------------------------------------
	localparam int unsigned ERRIN_DB_US [4]  = '{10, 25, 50, 100};
	localparam int unsigned FILT_STEP_NS     = 100;  // fast filter step 0.1 us
	localparam int unsigned FILT_STEP_CYC    = FILT_STEP_NS / CLK_PERIOD_NS;

	// ------------------------------------------------------------
	// register map, byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CFG   = 8'h00;  // delay selections
	localparam logic [7:0] OFS_FILT  = 8'h04;  // per-channel fast filter
	localparam logic [7:0] OFS_STAT  = 8'h08;  // sticky events, read clears
	localparam logic [7:0] OFS_MASK  = 8'h0C;  // interrupt enables
	localparam logic [7:0] OFS_STATE = 8'h10;  // live state, read only

	// ------------------------------------------------------------
	// fields and reset values
	// ------------------------------------------------------------
	localparam int unsigned CFG_RSTDLY_LSB = 0;   // 3 bits
	localparam int unsigned CFG_WDODLY_LSB = 4;   // 3 bits
	localparam int unsigned CFG_ESMDB_LSB  = 8;   // 2 bits
	localparam int unsigned FILT_W         = 10;  // bits per channel
	localparam logic [9:0]  FILT_RST       = 10'h3FF; // 102.4 us
	localparam int unsigned EV_UVOV        = 0;
	localparam int unsigned EV_ERRIN       = 1;
	localparam int unsigned EV_WD          = 2;
	localparam int unsigned EV_RDY         = 3;
	localparam int unsigned NUM_EV         = 4;
	localparam logic [3:0]  MASK_RST       = 4'hF;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef struct packed {
		logic [2:0] rst_dly;   // reset hold selection
		logic [2:0] wdf_dly;   // watchdog-fault hold selection
		logic [1:0] errin_db;  // error input debounce selection
	} sot_cfg_t;

	localparam sot_cfg_t CFG_RST = '{rst_dly: 3'h0, wdf_dly: 3'h0, errin_db: 2'h0};

	typedef struct packed {
		logic o;    // value driven, always low
		logic oe;   // high while pulling the pin low
	} sot_od_t;

	typedef enum logic [1:0] {
		SOT_PU_LOAD,   // configuration load
		SOT_PU_BIST,   // self test
		SOT_PU_READY   // running
	} sot_pu_t;

endpackage

// ### hdl/sot_filter.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// debounce: output rises after input held high len samples
// ------------------------------------------------------------
module sot_filter #(
	parameter int unsigned LEN_W = 11
) (
	// clock and reset
	input  wire logic             hclk,
	input  wire logic             hresetn,
	// level in, length in samples (at least one)
	input  wire logic             din,
	input  wire logic [LEN_W-1:0] len,
	// filtered level
	output logic                  qout
);

	logic [LEN_W-1:0] cnt_ff;   // samples of din high so far
	logic             q_ff;     // filtered level

	// count while high, saturating at len-1; a low sample restarts
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_ff <= '0;
		end else if (!din) begin
			cnt_ff <= '0;
		end else if (cnt_ff < len - 1'b1) begin
			cnt_ff <= cnt_ff + 1'b1;
		end
	end

	// release is immediate, so a cleared fault never lingers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q_ff <= 1'b0;
		end else begin
			q_ff <= din && (cnt_ff >= len - 1'b1);
		end
	end

	assign qout = q_ff;

	chk_flt_follow_low: assert property (@(posedge hclk) disable iff (!hresetn)
		!din |=> !q_ff) else $error("filter output stayed high after input fell");

	chk_flt_held_len: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(q_ff) |-> $past(cnt_ff) >= len - 1'b1)
		else $error("filter output rose before the hold length");

endmodule

// ### hdl/sot_core.sv
`timescale 1ns/100ps
module sot_core #(
	parameter int unsigned NUM_CH            = 3,
	parameter int unsigned LOAD_US           = 1000,   // configuration load time
	parameter int unsigned BIST_US           = 10000,  // self test time
	parameter int unsigned READY_BIST_MAX_US = 12000,
	parameter int unsigned READY_NBST_MAX_US = 2000,
	parameter int unsigned RST_DLY_US [8]    = '{200, 1000, 10000, 16000,
		20000, 70000, 100000, 200000},
	parameter int unsigned WDF_DLY_US [8]    = '{1000, 2000, 5000, 10000,
		20000, 50000, 100000, 200000}
) (
	// clock and reset
	input  wire logic              hclk,
	input  wire logic              hresetn,
	// ahb-lite slave
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic              hready,
	input  wire logic [31:0]       hwdata,
	output logic                   hreadyout,
	output logic                   hresp,
	output logic [31:0]            hrdata,
	// monitored conditions
	input  wire logic [NUM_CH-1:0] mon_fault,
	input  wire logic              error_signal_input,
	input  wire logic              wd_violation,
	input  wire logic              selftest_on_powerup,
	// open-drain outputs and their sensed levels
	output sot_pkg::sot_od_t       reset_out_n,
	output sot_pkg::sot_od_t       irq_out_n,
	output sot_pkg::sot_od_t       watchdog_fault_out_n,
	input  wire logic              reset_out_n_sense,
	input  wire logic              irq_out_n_sense,
	input  wire logic              watchdog_fault_out_n_sense
);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// microseconds to hclk cycles
	function automatic logic [31:0] to_cyc(input int unsigned us);
		return 32'(us * sot_pkg::CLK_PER_US);
	endfunction

	localparam logic [31:0] LOAD_CYC = 32'(LOAD_US * sot_pkg::CLK_PER_US);
	localparam logic [31:0] BIST_CYC = 32'(BIST_US * sot_pkg::CLK_PER_US);
	localparam logic [31:0] RDY_BIST = 32'(READY_BIST_MAX_US * sot_pkg::CLK_PER_US);
	localparam logic [31:0] RDY_NBST = 32'(READY_NBST_MAX_US * sot_pkg::CLK_PER_US);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	sot_pkg::sot_pu_t               pu_ff;        // power-up phase
	logic [31:0]                    pu_cnt_ff;    // phase timer
	logic                           bist_sel_ff;  // strap caught at load end
	logic                           ready;        // running
	sot_pkg::sot_cfg_t              cfg_ff;       // delay selections
	logic [NUM_CH*sot_pkg::FILT_W-1:0] filt_ff;   // fast filter codes
	logic [sot_pkg::NUM_EV-1:0]     stat_ff;      // sticky events
	logic [sot_pkg::NUM_EV-1:0]     mask_ff;      // interrupt enables
	logic [sot_pkg::NUM_EV-1:0]     ev;           // event pulses
	logic [NUM_CH-1:0]              ch_flt;       // debounced window faults
	logic                           uvov_flt;     // any window fault
	logic                           errin_flt;    // debounced error input
	logic                           uvov_q_ff;    // edge history
	logic                           errin_q_ff;
	logic                           rdy_q_ff;
	logic [31:0]                    rst_cnt_ff;   // reset hold timer
	logic [31:0]                    wdf_cnt_ff;   // watchdog-fault hold timer
	logic                           rst_on_ff;
	logic                           wdf_on_ff;
	logic                           irq_on_ff;
	// bus
	logic                           pend_ff;      // data phase outstanding
	logic                           wr_ff;
	logic [7:0]                     addr_ff;
	logic                           hready_ff;
	logic [31:0]                    hrdata_ff;
	logic                           do_acc;       // access completes now
	logic                           stat_rd;      // status read, clears

	// ------------------------------------------------------------
	// power-up sequence
	// ------------------------------------------------------------
	assign ready = (pu_ff == sot_pkg::SOT_PU_READY);

	// load, optional self test, then ready
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pu_ff     <= sot_pkg::SOT_PU_LOAD;
			pu_cnt_ff <= '0;
		end else begin
			case (pu_ff)
				sot_pkg::SOT_PU_LOAD: begin
					if (pu_cnt_ff == LOAD_CYC - 1) begin
						pu_cnt_ff <= '0;
						// strap chooses self test
						pu_ff <= selftest_on_powerup ? sot_pkg::SOT_PU_BIST
							: sot_pkg::SOT_PU_READY;
					end else begin
						pu_cnt_ff <= pu_cnt_ff + 1;
					end
				end
				sot_pkg::SOT_PU_BIST: begin
					if (pu_cnt_ff == BIST_CYC - 1) begin
						pu_ff <= sot_pkg::SOT_PU_READY;
					end else begin
						pu_cnt_ff <= pu_cnt_ff + 1;
					end
				end
				sot_pkg::SOT_PU_READY: begin
					pu_cnt_ff <= pu_cnt_ff;
				end
				default: begin
					pu_ff <= sot_pkg::SOT_PU_LOAD;
				end
			endcase
		end
	end

	// strap is caught by the clock, never by the reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bist_sel_ff <= 1'b1;
		end else if (pu_ff == sot_pkg::SOT_PU_LOAD && pu_cnt_ff == LOAD_CYC - 1) begin
			bist_sel_ff <= selftest_on_powerup;
		end
	end

	// ------------------------------------------------------------
	// fault filters
	// ------------------------------------------------------------
	// one filter per channel, step of 0.1 us per code
	generate
		for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
			sot_filter #(.LEN_W(11)) u_flt (
				.hclk    (hclk),
				.hresetn (hresetn),
				.din     (mon_fault[ch]),
				.len     (11'(filt_ff[ch*sot_pkg::FILT_W +: sot_pkg::FILT_W])
					+ 11'(sot_pkg::FILT_STEP_CYC)),
				.qout    (ch_flt[ch])
			);
		end
	endgenerate

	// error input debounce from the 2-bit code
	sot_filter #(.LEN_W(11)) u_errin (
		.hclk    (hclk),
		.hresetn (hresetn),
		.din     (error_signal_input),
		.len     (11'(to_cyc(sot_pkg::ERRIN_DB_US[cfg_ff.errin_db]))),
		.qout    (errin_flt)
	);

	assign uvov_flt = |ch_flt;

	// ------------------------------------------------------------
	// events and interrupt
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			uvov_q_ff <= 1'b0;
			errin_q_ff <= 1'b0;
			rdy_q_ff  <= 1'b0;
		end else begin
			uvov_q_ff <= uvov_flt;
			errin_q_ff <= errin_flt;
			rdy_q_ff  <= ready;
		end
	end

	always_comb begin
		ev                   = '0;
		ev[sot_pkg::EV_UVOV] = uvov_flt & ~uvov_q_ff;
		ev[sot_pkg::EV_ERRIN] = errin_flt & ~errin_q_ff;
		ev[sot_pkg::EV_WD]   = wd_violation & ready;
		ev[sot_pkg::EV_RDY]  = ready & ~rdy_q_ff;
	end

	// sticky; an event in the clearing read's cycle survives it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stat_ff <= '0;
		end else begin
			stat_ff <= (stat_ff & ~{sot_pkg::NUM_EV{stat_rd}}) | ev;
		end
	end

	// level interrupt while any enabled bit stands
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_on_ff <= 1'b0;
		end else begin
			irq_on_ff <= |(stat_ff & mask_ff);
		end
	end

	// ------------------------------------------------------------
	// reset and watchdog-fault timers
	// ------------------------------------------------------------
	// asserted while not ready or faulted, then held the selected time
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rst_on_ff  <= 1'b1;
			rst_cnt_ff <= '0;
		end else if (!ready || uvov_flt || errin_flt) begin
			rst_on_ff  <= 1'b1;
			rst_cnt_ff <= '0;
		end else if (rst_on_ff) begin
			if (rst_cnt_ff >= to_cyc(RST_DLY_US[cfg_ff.rst_dly]) - 1) begin
				rst_on_ff <= 1'b0;
			end else begin
				rst_cnt_ff <= rst_cnt_ff + 1;
			end
		end
	end

	// each violation while ready restarts the selected hold
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wdf_on_ff  <= 1'b0;
			wdf_cnt_ff <= '0;
		end else if (wd_violation && ready) begin
			wdf_on_ff  <= 1'b1;
			wdf_cnt_ff <= '0;
		end else if (wdf_on_ff) begin
			if (wdf_cnt_ff >= to_cyc(WDF_DLY_US[cfg_ff.wdf_dly]) - 1) begin
				wdf_on_ff <= 1'b0;
			end else begin
				wdf_cnt_ff <= wdf_cnt_ff + 1;
			end
		end
	end

	assign reset_out_n          = '{o: 1'b0, oe: rst_on_ff};
	assign irq_out_n            = '{o: 1'b0, oe: irq_on_ff};
	assign watchdog_fault_out_n = '{o: 1'b0, oe: wdf_on_ff};

	// ------------------------------------------------------------
	// ahb-lite slave
	// ------------------------------------------------------------
	// data phase is stalled until ready, so nothing lands mid self test
	assign do_acc  = pend_ff && ready;
	assign stat_rd = do_acc && !wr_ff && addr_ff == sot_pkg::OFS_STAT;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pend_ff   <= 1'b0;
			wr_ff     <= 1'b0;
			addr_ff   <= '0;
			hready_ff <= 1'b1;
		end else if (hsel && htrans[1] && hready) begin
			pend_ff   <= 1'b1;
			wr_ff     <= hwrite;
			addr_ff   <= haddr[7:0];
			hready_ff <= 1'b0;
		end else if (do_acc) begin
			pend_ff   <= 1'b0;
			hready_ff <= 1'b1;
		end
	end

	// software-written registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_ff  <= sot_pkg::CFG_RST;
			filt_ff <= {NUM_CH{sot_pkg::FILT_RST}};
			mask_ff <= sot_pkg::MASK_RST;
		end else if (do_acc && wr_ff) begin
			case (addr_ff)
				sot_pkg::OFS_CFG: begin
					cfg_ff.rst_dly <= hwdata[sot_pkg::CFG_RSTDLY_LSB +: 3];
					cfg_ff.wdf_dly  <= hwdata[sot_pkg::CFG_WDODLY_LSB +: 3];
					cfg_ff.errin_db <= hwdata[sot_pkg::CFG_ESMDB_LSB +: 2];
				end
				sot_pkg::OFS_FILT: filt_ff <= hwdata[NUM_CH*sot_pkg::FILT_W-1:0];
				sot_pkg::OFS_MASK: mask_ff <= hwdata[sot_pkg::NUM_EV-1:0];
				default: begin
					// read-only or unmapped: ignored
				end
			endcase
		end
	end

	// read data; unmapped reads as zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_ff <= '0;
		end else if (do_acc && !wr_ff) begin
			hrdata_ff <= '0;
			case (addr_ff)
				sot_pkg::OFS_CFG: begin
					hrdata_ff[sot_pkg::CFG_RSTDLY_LSB +: 3] <= cfg_ff.rst_dly;
					hrdata_ff[sot_pkg::CFG_WDODLY_LSB +: 3] <= cfg_ff.wdf_dly;
					hrdata_ff[sot_pkg::CFG_ESMDB_LSB +: 2]  <= cfg_ff.errin_db;
				end
				sot_pkg::OFS_FILT:  hrdata_ff[NUM_CH*sot_pkg::FILT_W-1:0] <= filt_ff;
				sot_pkg::OFS_STAT:  hrdata_ff[sot_pkg::NUM_EV-1:0] <= stat_ff;
				sot_pkg::OFS_MASK:  hrdata_ff[sot_pkg::NUM_EV-1:0] <= mask_ff;
				sot_pkg::OFS_STATE: hrdata_ff[12:0] <= {bist_sel_ff, ready,
					watchdog_fault_out_n_sense, irq_out_n_sense, reset_out_n_sense,
					errin_flt, 4'(ch_flt), 3'(pu_ff)};
				default: hrdata_ff <= '0;
			endcase
		end
	end

	assign hreadyout = hready_ff;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_ff;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	logic [31:0] up_cnt_ff; // cycles since reset release, until ready
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			up_cnt_ff <= '0;
		end else if (!ready) begin
			up_cnt_ff <= up_cnt_ff + 1;
		end
	end

	sequence s_fault_seen;
		$rose(uvov_flt || errin_flt);
	endsequence

	chk_ready_with_bist: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(ready) && bist_sel_ff |-> up_cnt_ff <= RDY_BIST)
		else $error("ready too late with self test");
	chk_ready_no_bist: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(ready) && !bist_sel_ff |-> up_cnt_ff <= RDY_NBST)
		else $error("ready too late without self test");
	chk_bus_at_ready: assert property (@(posedge hclk) disable iff (!hresetn)
		pend_ff && ready |=> hready_ff && !pend_ff)
		else $error("bus not answered once ready");
	chk_reset_on_fault: assert property (@(posedge hclk) disable iff (!hresetn)
		s_fault_seen |=> reset_out_n.oe [*2])
		else $error("reset not asserted after fault");
	chk_wdf_on_viol: assert property (@(posedge hclk) disable iff (!hresetn)
		wd_violation && ready |=> watchdog_fault_out_n.oe)
		else $error("watchdog fault output late");
	chk_irq_on_error: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(errin_flt) && mask_ff[sot_pkg::EV_ERRIN] |-> ##[1:2] irq_out_n.oe)
		else $error("interrupt late for error input");
	chk_fast_path: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(mon_fault[0]) && filt_ff[sot_pkg::FILT_W-1:0] == '0 ##1 mon_fault[0]
		|-> ##[0:4] rst_on_ff)
		else $error("fast path detect too slow");
	chk_reset_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		$fell(rst_on_ff) |-> rst_cnt_ff == to_cyc(RST_DLY_US[cfg_ff.rst_dly]) - 1)
		else $error("reset released off the selected delay");
	chk_wdf_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		$fell(wdf_on_ff) |-> wdf_cnt_ff == to_cyc(WDF_DLY_US[cfg_ff.wdf_dly]) - 1)
		else $error("watchdog fault released off the selected delay");
	chk_window_flag: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(uvov_flt) |=> stat_ff[sot_pkg::EV_UVOV])
		else $error("window fault not flagged");

endmodule

// ### bench/sot_host_model.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// host side: pull-ups on the three open-drain pins
// ------------------------------------------------------------
module sot_host_model (
	// pins from the supervisor
	input  sot_pkg::sot_od_t rst_pin,
	input  sot_pkg::sot_od_t irq_pin,
	input  sot_pkg::sot_od_t wdf_pin,
	// resolved levels seen by the host
	output logic             rst_sense,
	output logic             irq_sense,
	output logic             wdf_sense
);
	// released pin floats to the pull-up, so it never keeps a stale low
	assign rst_sense = rst_pin.oe ? rst_pin.o : 1'h1;
	assign irq_sense = irq_pin.oe ? irq_pin.o : 1'h1;
	assign wdf_sense = wdf_pin.oe ? wdf_pin.o : 1'h1;
endmodule

// ### bench/supervisor_output_timing_tb.sv
`timescale 1ns/100ps
module supervisor_output_timing_tb;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	localparam int unsigned RDLY [8] = '{3, 4, 5, 6, 7, 8, 9, 10}; // shortened holds, us
	localparam int unsigned WDLY [8] = '{2, 3, 4, 5, 6, 7, 8, 9};
	logic             hclk, hresetn, hsel, hwrite, strap, esi, wdv;
	logic             hreadyout, hresp, rdy_s;
	logic [1:0]       htrans;
	logic [2:0]       mon, pins, pins_s;  // pins: {wdo, irq, rst}
	logic [31:0]      haddr, hwdata, hrdata, rd_s, rd;
	sot_pkg::sot_od_t rst_o, irq_o, wdf_o;
	int               n_errors, n_tests, cyc, n, t0;

	sot_core #(.LOAD_US(2), .BIST_US(5), .READY_BIST_MAX_US(12), .READY_NBST_MAX_US(2),
		.RST_DLY_US(RDLY), .WDF_DLY_US(WDLY)) dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .mon_fault(mon),
		.error_signal_input(esi), .wd_violation(wdv), .selftest_on_powerup(strap),
		.reset_out_n(rst_o), .irq_out_n(irq_o), .watchdog_fault_out_n(wdf_o),
		.reset_out_n_sense(pins[0]), .irq_out_n_sense(pins[1]),
		.watchdog_fault_out_n_sense(pins[2]));

	sot_host_model host (.rst_pin(rst_o), .irq_pin(irq_o), .wdf_pin(wdf_o),
		.rst_sense(pins[0]), .irq_sense(pins[1]), .wdf_sense(pins[2]));

	// ------------------------------------------------------------
	// clock, settled copies of outputs, hang guard
	// ------------------------------------------------------------
	initial begin
		hclk = 1'h0;
		forever #50 hclk = ~hclk;
	end
	// negedge copies give the value held before the next rising edge
	always @(negedge hclk) begin
		rdy_s = hreadyout;
		rd_s = hrdata;
		pins_s = pins;
	end
	always @(posedge hclk) begin
		cyc = cyc + 1;
		if (cyc > 20000) begin
			n_errors++;
			wrap_up();
		end
	end

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task check(input logic [31:0] got, input logic [31:0] exp, input int tol);
		n_tests++;
		if ((tol == 0) ? (got !== exp) : (got > exp + tol || got + tol < exp)) begin
			n_errors++;
			$display("unexpected at %0t: got %0h, expected %0h", $time, got, exp);
		end
	endtask
	// one single transfer; called right after a rising edge
	task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'h1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= w;
		n = 0;
		do begin @(posedge hclk); n++; end while (rdy_s !== 1'h1 && n < 3000);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= wd;
		n = 0;
		do begin @(posedge hclk); n++; end while (rdy_s !== 1'h1 && n < 3000);
		rd = rd_s;
		check(32'(hresp), 32'h0, 0);
	endtask
	// edges until pin i shows lvl, bounded
	task wait_pin(input int i, input logic lvl, input int lim);
		n = 0;
		do begin @(posedge hclk); n++; end while (pins_s[i] !== lvl && n < lim);
	endtask
	// reset, then a STATE read that stalls until the block is ready
	task power_up(input logic st);
		hresetn <= 1'h0;
		strap <= st;
		repeat (8) @(posedge hclk);
		check(32'(pins_s[0]), 32'h0, 0);
		hresetn <= 1'h1;
		t0 = cyc;
		ahb(1'h0, sot_pkg::OFS_STATE, 32'h0);
	endtask
	task wrap_up;
		$display("comparisons %0d, mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		{hresetn, hsel, hwrite, esi, wdv, mon, htrans} = '0;
		{haddr, hwdata} = '0;
		{n_errors, n_tests, cyc} = '0;
		strap = 1'h1;
		// power-up with self test, registers at their defaults
		power_up(1'h1);
		check(32'(rd[11]), 32'h1, 0);
		check(32'(cyc - t0 <= 120), 32'h1, 0);
		check(32'(cyc - t0 <= 74), 32'h1, 0);
		check(32'(rd[12]), 32'h1, 0);
		ahb(1'h0, sot_pkg::OFS_CFG, 32'h0);
		check(rd, 32'h0, 0);
		ahb(1'h0, sot_pkg::OFS_FILT, 32'h0);
		check(rd, 32'h3FFFFFFF, 0);
		ahb(1'h0, sot_pkg::OFS_MASK, 32'h0);
		check(rd, 32'hF, 0);
		ahb(1'h1, sot_pkg::OFS_STAT, 32'hF);
		ahb(1'h0, sot_pkg::OFS_STAT, 32'h0);
		check(32'(rd[3]), 32'h1, 0);
		ahb(1'h0, sot_pkg::OFS_STAT, 32'h0);
		check(rd, 32'h0, 0);
		ahb(1'h0, 8'h20, 32'h0);
		check(rd, 32'h0, 0);
		wait_pin(0, 1'h1, 3000);
		// window fault on ch0, shortest filter, every hold code
		ahb(1'h1, sot_pkg::OFS_FILT, 32'h3FFFFC00);
		for (int c = 0; c < 8; c++) begin
			ahb(1'h1, sot_pkg::OFS_CFG, 32'(c));
			mon[0] <= 1'h1;
			wait_pin(0, 1'h0, 50);
			check(32'(n <= sot_pkg::FAST_1X_CYC), 32'h1, 0);
			mon[0] <= 1'h0;
			wait_pin(0, 1'h1, 3000);
			check(32'(n), 32'(RDLY[c] * 10), 5);
		end
		ahb(1'h0, sot_pkg::OFS_STAT, 32'h0);
		check(32'(rd[0]), 32'h1, 0);
		wait_pin(1, 1'h1, 20);
		check(32'(pins_s[1]), 32'h1, 0);
		// error input debounce codes
		for (int c = 0; c < 4; c++) begin
			ahb(1'h1, sot_pkg::OFS_CFG, 32'(c << 8));
			esi <= 1'h1;
			wait_pin(0, 1'h0, 3000);
			check(32'(n), 32'(sot_pkg::ERRIN_DB_US[c] * 10), 5);
			wait_pin(1, 1'h0, sot_pkg::FLAG_LAT_CYC);
			check(32'(pins_s[1]), 32'h0, 0);
			esi <= 1'h0;
			ahb(1'h0, sot_pkg::OFS_STAT, 32'h0);
			wait_pin(0, 1'h1, 3000);
		end
		// watchdog violation pulse, every hold code
		for (int c = 0; c < 8; c++) begin
			ahb(1'h1, sot_pkg::OFS_CFG, 32'(c << 4));
			wdv <= 1'h1;
			@(posedge hclk);
			wdv <= 1'h0;
			wait_pin(2, 1'h0, sot_pkg::FLAG_LAT_CYC);
			check(32'(pins_s[2]), 32'h0, 0);
			wait_pin(2, 1'h1, 3000);
			check(32'(n), 32'(WDLY[c] * 10), 5);
			check(32'(pins_s[1]), 32'h0, 0);
			ahb(1'h0, sot_pkg::OFS_STAT, 32'h0);
		end
		// longest window filter with the interrupt masked, then unmasked
		ahb(1'h1, sot_pkg::OFS_MASK, 32'h0);
		ahb(1'h1, sot_pkg::OFS_FILT, 32'h3FFFFFFF);
		mon[1] <= 1'h1;
		wait_pin(0, 1'h0, 2000);
		check(32'(n), 32'd1026, 5);
		check(32'(pins_s[1]), 32'h1, 0);
		ahb(1'h1, sot_pkg::OFS_MASK, 32'hF);
		wait_pin(1, 1'h0, 20);
		check(32'(pins_s[1]), 32'h0, 0);
		mon[1] <= 1'h0;
		ahb(1'h0, sot_pkg::OFS_STAT, 32'h0);
		check(32'(rd[0]), 32'h1, 0);
		wait_pin(1, 1'h1, 20);
		check(32'(pins_s[1]), 32'h1, 0);
		wait_pin(0, 1'h1, 3000);
		// second reset mid-run, self test strapped off
		power_up(1'h0);
		check(32'(cyc - t0 <= 24), 32'h1, 0);
		check(32'(rd[12]), 32'h0, 0);
		wrap_up();
	end
endmodule
